// ===== shared/adcg_pkg.sv
// constants for the global configuration register set
package adcg_pkg;
   // register addresses
   localparam logic [4:0] ADDR_RATE_CLK = 5'h01;
   localparam logic [4:0] ADDR_TEST_SIG = 5'h02;
   localparam logic [4:0] ADDR_REF_AMP = 5'h03;
   localparam logic [4:0] ADDR_FAULT_TH = 5'h04;
   // reset values
   localparam logic [7:0] RST_RATE_CLK = 8'h91;
   localparam logic [7:0] RST_TEST_SIG = 8'he0;
   localparam logic [7:0] RST_REF_AMP = 8'h40;
   localparam logic [7:0] RST_FAULT_TH = 8'h00;
   // field positions
   localparam int BIT_READBACK = 6;
   localparam int BIT_OSC_OUT = 5;
   localparam int RATE_LSB = 0;
   localparam int BIT_TEST_INT = 4;
   localparam int BIT_TEST_AMP = 2;
   localparam int TFREQ_LSB = 0;
   localparam int BIT_REF_BUF = 7;
   localparam int BIT_REF_FIXED = 6;
   localparam int BIT_HIGH_REF = 5;
   localparam int BIT_AMP_ROUTE = 3;
   localparam int BIT_AMP_PWR = 2;
   localparam int TH_LSB = 5;
   // encodings
   localparam logic [2:0] RATE_FIRST_24 = 3'h2;
   localparam logic [2:0] RATE_FORBIDDEN = 3'h7;
   localparam logic [6:0] RATE_MAX_KSPS = 7'h40;
   localparam logic [1:0] TFREQ_SLOW = 2'h0;
   localparam logic [1:0] TFREQ_FAST = 2'h1;
   localparam logic [1:0] TFREQ_DC = 2'h3;
   localparam logic [2:0] OPC_WRITE = 3'h2;
   localparam logic [9:0] PERMILLE_FULL = 10'h3e8;
   // modulator enable divider: master clock divided by two
   localparam int MOD_DIV = 2;
   localparam int TEST_DIV_LOG2 = 21;
endpackage

// ===== shared/adcg_wr_if.sv
// register write channel between command parser and register bank
`timescale 1ns/1ps
interface adcg_wr_if;
   logic wr_en;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;
   modport src (output wr_en, output wr_addr, output wr_data);
   modport dst (input wr_en, input wr_addr, input wr_data);
endinterface

// ===== core/adcg_cmd_parser.sv
// write-command parser: opcode byte, count byte, then data bytes msb first
`timescale 1ns/1ps
module adcg_cmd_parser (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // byte stream from the serial port
   input wire logic frame_active,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   // register writes
   adcg_wr_if.src wr
);
   typedef enum logic [1:0] {PS_OPC, PS_CNT, PS_DATA, PS_SKIP} adcg_pstate_t;
   adcg_pstate_t state_q, state_d;
   logic [4:0] addr_q, addr_d;
   logic [4:0] left_q, left_d;
   wire logic take = frame_active && byte_valid;
   wire logic is_write = byte_data[7:5] == adcg_pkg::OPC_WRITE;

   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      left_d = left_q;
      if (!frame_active) begin
         state_d = PS_OPC;
      end else if (take) begin
         case (state_q)
            PS_OPC: begin
               addr_d = byte_data[4:0];
               state_d = is_write ? PS_CNT : PS_SKIP;
            end
            PS_CNT: begin
               left_d = byte_data[4:0];
               state_d = PS_DATA;
            end
            PS_DATA: begin
               addr_d = addr_q + 5'h01;
               left_d = left_q - 5'h01;
               if (left_q == 5'h00) begin
                  state_d = PS_SKIP;
               end
            end
            default: state_d = PS_SKIP;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= PS_OPC;
         addr_q <= 5'h00;
         left_q <= 5'h00;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         left_q <= left_d;
      end
   end

   assign wr.wr_en = take && state_q == PS_DATA;
   assign wr.wr_addr = addr_q;
   assign wr.wr_data = byte_data;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   chk_write_needs_opcode: assert property (
      take && state_q == PS_OPC && !is_write |=> (!wr.wr_en) [*3])
      else $error("write issued after a refused opcode");
   chk_skip_after_count: assert property (
      take && state_q == PS_DATA && left_q == 5'h00 |=> state_q == PS_SKIP || !frame_active)
      else $error("data phase did not end after count");
   cov_write_burst: cover property (wr.wr_en ##[1:40] wr.wr_en);
endmodule

// ===== core/adcg_config_regs.sv
// global configuration register bank with decoded controls
`timescale 1ns/1ps
module adcg_config_regs #(
   parameter int TEST_DIV_LOG2 = adcg_pkg::TEST_DIV_LOG2
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // command byte stream
   input wire logic frame_active,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   // register read port
   input wire logic [4:0] rd_addr,
   output logic [7:0] rd_data,
   // pin
   input wire logic clock_source_pin,
   // rate and clock controls
   output logic multi_readback_mode,
   output logic osc_out_en,
   output logic [2:0] output_rate_code,
   output logic [6:0] rate_ksps,
   output logic resolution_24,
   output logic rate_invalid,
   output logic mod_clk_en,
   // test signal controls
   output logic test_internal,
   output logic test_amp_double,
   output logic test_wave,
   // reference and op amp controls
   output logic ref_buffer_on,
   output logic high_reference_sel,
   output logic amp_input_route,
   output logic amp_power_on,
   // comparator levels in tenths of a percent
   output logic [9:0] high_level_pm,
   output logic [9:0] low_level_pm
);
   adcg_wr_if wr ();

   adcg_cmd_parser u_parser (
      .clock(clock),
      .srst(srst),
      .frame_active(frame_active),
      .byte_valid(byte_valid),
      .byte_data(byte_data),
      .wr(wr)
   );

   function automatic logic [9:0] high_level(input logic [2:0] code);
      case (code)
         3'h0: high_level = 10'h3b6;
         3'h1: high_level = 10'h39d;
         3'h2: high_level = 10'h384;
         3'h3: high_level = 10'h36b;
         3'h4: high_level = 10'h352;
         3'h5: high_level = 10'h320;
         3'h6: high_level = 10'h2ee;
         default: high_level = 10'h2bc;
      endcase
   endfunction

   logic [7:0] rate_q, test_q, ref_q, fault_q;
   logic [7:0] rd_data_q;
   logic [2:0] pin_sync_q;
   logic pin_level_q;
   logic mod_cnt_q;
   logic [TEST_DIV_LOG2-1:0] tcnt_q;

   wire logic wr_rate = wr.wr_en && wr.wr_addr == adcg_pkg::ADDR_RATE_CLK;
   wire logic wr_test = wr.wr_en && wr.wr_addr == adcg_pkg::ADDR_TEST_SIG;
   wire logic wr_ref = wr.wr_en && wr.wr_addr == adcg_pkg::ADDR_REF_AMP;
   wire logic wr_fault = wr.wr_en && wr.wr_addr == adcg_pkg::ADDR_FAULT_TH;
   wire logic [7:0] rd_mux =
      rd_addr == adcg_pkg::ADDR_RATE_CLK ? rate_q :
      rd_addr == adcg_pkg::ADDR_TEST_SIG ? test_q :
      rd_addr == adcg_pkg::ADDR_REF_AMP ? ref_q :
      rd_addr == adcg_pkg::ADDR_FAULT_TH ? fault_q : 8'h00;
   wire logic [1:0] tfreq = test_q[adcg_pkg::TFREQ_LSB +: 2];
   wire logic [2:0] th_code = fault_q[adcg_pkg::TH_LSB +: 3];

   // whole bytes are stored so fixed bits read back as written
   always_ff @(posedge clock) begin
      if (srst) begin
         rate_q <= adcg_pkg::RST_RATE_CLK;
         test_q <= adcg_pkg::RST_TEST_SIG;
         ref_q <= adcg_pkg::RST_REF_AMP;
         fault_q <= adcg_pkg::RST_FAULT_TH;
      end else begin
         if (wr_rate) rate_q <= wr.wr_data;
         if (wr_test) test_q <= wr.wr_data;
         if (wr_ref) ref_q <= wr.wr_data;
         if (wr_fault) fault_q <= wr.wr_data;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rd_mux;
      end
   end

   // pin passes three flops; level changes once the last two agree
   always_ff @(posedge clock) begin
      if (srst) begin
         pin_sync_q <= 3'h0;
         pin_level_q <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], clock_source_pin};
         if (pin_sync_q[1] == pin_sync_q[2]) pin_level_q <= pin_sync_q[2];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         mod_cnt_q <= 1'b0;
         tcnt_q <= '0;
      end else begin
         mod_cnt_q <= ~mod_cnt_q;
         tcnt_q <= tcnt_q + 1'b1;
      end
   end

   assign rd_data = rd_data_q;
   assign mod_clk_en = mod_cnt_q;
   assign multi_readback_mode = rate_q[adcg_pkg::BIT_READBACK];
   assign osc_out_en = rate_q[adcg_pkg::BIT_OSC_OUT] && pin_level_q;
   assign output_rate_code = rate_q[adcg_pkg::RATE_LSB +: 3];
   assign rate_invalid = output_rate_code == adcg_pkg::RATE_FORBIDDEN;
   assign resolution_24 = output_rate_code >= adcg_pkg::RATE_FIRST_24 && !rate_invalid;
   assign rate_ksps = rate_invalid ? 7'h00 : adcg_pkg::RATE_MAX_KSPS >> output_rate_code;
   assign test_internal = test_q[adcg_pkg::BIT_TEST_INT];
   assign test_amp_double = test_q[adcg_pkg::BIT_TEST_AMP];
   // square wave: msb gives master/2^N, next bit master/2^(N-1); unused code holds low
   assign test_wave = tfreq == adcg_pkg::TFREQ_SLOW ? tcnt_q[TEST_DIV_LOG2-1] :
                      tfreq == adcg_pkg::TFREQ_FAST ? tcnt_q[TEST_DIV_LOG2-2] :
                      tfreq == adcg_pkg::TFREQ_DC;
   assign ref_buffer_on = ref_q[adcg_pkg::BIT_REF_BUF];
   assign high_reference_sel = ref_q[adcg_pkg::BIT_HIGH_REF];
   assign amp_input_route = ref_q[adcg_pkg::BIT_AMP_ROUTE];
   assign amp_power_on = ref_q[adcg_pkg::BIT_AMP_PWR];
   assign high_level_pm = high_level(th_code);
   assign low_level_pm = adcg_pkg::PERMILLE_FULL - high_level_pm;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   chk_reset_defaults: assert property ($past(srst) |-> rate_q == adcg_pkg::RST_RATE_CLK &&
      test_q == adcg_pkg::RST_TEST_SIG && fault_q == adcg_pkg::RST_FAULT_TH)
      else $error("register default wrong after reset");
   chk_fixed_bit_boot: assert property ($past(srst) |-> ref_q[adcg_pkg::BIT_REF_FIXED])
      else $error("reference fixed bit not one after reset");
   chk_readback_write: assert property (wr_rate |=>
      multi_readback_mode == $past(wr.wr_data[adcg_pkg::BIT_READBACK]))
      else $error("read-back mode did not follow write");
   chk_osc_out_gate: assert property (osc_out_en |->
      rate_q[adcg_pkg::BIT_OSC_OUT] && $past(clock_source_pin, 4))
      else $error("oscillator output enabled without cause");
   chk_rate_width: assert property (resolution_24 |->
      output_rate_code inside {[3'h2:3'h6]} && rate_ksps <= 7'h10)
      else $error("rate resolution mismatch");
   chk_mod_half: assert property (mod_clk_en |=> !mod_clk_en ##1 mod_clk_en)
      else $error("modulator enable not divide by two");
   chk_test_dc: assert property (tfreq == adcg_pkg::TFREQ_DC |-> test_wave)
      else $error("constant test level missing");
   chk_refbuf_write: assert property (wr_ref |=>
      ref_buffer_on == $past(wr.wr_data[adcg_pkg::BIT_REF_BUF]))
      else $error("reference buffer did not follow write");
   chk_level_pair: assert property (th_code == 3'h0 |->
      high_level_pm == 10'h3b6 && low_level_pm == 10'h032)
      else $error("comparator levels wrong at default code");
   chk_level_last: assert property (th_code == 3'h7 |->
      high_level_pm == 10'h2bc && low_level_pm == 10'h12c)
      else $error("comparator levels wrong at last code");
   chk_read_latency: assert property (1'b1 |=> rd_data == $past(rd_mux))
      else $error("read data not one cycle behind address");
   chk_read_unmapped: assert property (
      !(rd_addr inside {[adcg_pkg::ADDR_RATE_CLK:adcg_pkg::ADDR_FAULT_TH]})
      |=> rd_data == 8'h00)
      else $error("unmapped address returned data");
   // controls follow the byte just written
   chk_test_write: assert property (wr_test |=>
      test_internal == $past(wr.wr_data[adcg_pkg::BIT_TEST_INT]) &&
      test_amp_double == $past(wr.wr_data[adcg_pkg::BIT_TEST_AMP]))
      else $error("test source or amplitude did not follow write");
   chk_ref_write: assert property (wr_ref |=>
      high_reference_sel == $past(wr.wr_data[adcg_pkg::BIT_HIGH_REF]) &&
      amp_input_route == $past(wr.wr_data[adcg_pkg::BIT_AMP_ROUTE]) &&
      amp_power_on == $past(wr.wr_data[adcg_pkg::BIT_AMP_PWR]))
      else $error("reference level or op amp did not follow write");
   chk_rate_invalid: assert property (output_rate_code == 3'h7 |->
      rate_invalid && rate_ksps == 7'h00 && !resolution_24)
      else $error("forbidden rate code not flagged");
   chk_test_unused: assert property (tfreq == 2'h2 |-> !test_wave)
      else $error("unused test frequency code not held low");
   chk_mod_reset_low: assert property ($past(srst) |-> !mod_clk_en)
      else $error("modulator enable high right after reset");

   cov_rate_write: cover property (wr_rate ##1 resolution_24);
   cov_test_fast: cover property (test_internal && tfreq == adcg_pkg::TFREQ_FAST);
   cov_osc_on: cover property (osc_out_en);
   cov_rate_bad: cover property (rate_invalid);
endmodule

// ===== testbench/adcg_host_model.sv
// host controller model: sends register write frames byte by byte
`timescale 1ns/1ps
module adcg_host_model (
   // clock
   input wire logic clock,
   // byte stream towards the device
   output logic frame_active,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   initial begin
      frame_active = 1'b0;
      byte_valid = 1'b0;
      byte_data = 8'h00;
   end
   // one byte a cycle, changed only at the falling edge
   task automatic send(input logic [7:0] bytes[$]);
      @(negedge clock);
      frame_active = 1'b1;
      foreach (bytes[i]) begin
         byte_valid = 1'b1;
         byte_data = bytes[i];
         @(negedge clock);
      end
      byte_valid = 1'b0;
      // a stale byte is not left on the lines
      byte_data = ~byte_data;
      frame_active = 1'b0;
   endtask
   task automatic register_write_cmd(input logic [4:0] addr, input logic [7:0] data[$]);
      logic [7:0] bytes[$];
      bytes = data;
      bytes.push_front({3'h0, 5'(data.size() - 1)});
      bytes.push_front({3'h2, addr});
      send(bytes);
   endtask
endmodule

// ===== testbench/adcg_config_regs_tb.sv
// self-checking bench for the global configuration register bank
`timescale 1ns/1ps
module adcg_config_regs_tb;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic clock_source_pin = 1'b0;
   logic frame_active, byte_valid, multi_readback_mode, osc_out_en, resolution_24;
   logic rate_invalid, mod_clk_en, test_internal, test_amp_double, test_wave;
   logic ref_buffer_on, high_reference_sel, amp_input_route, amp_power_on, last_wave;
   logic [7:0] byte_data, rd_data;
   logic [4:0] rd_addr = 5'h00;
   logic [2:0] output_rate_code;
   logic [6:0] rate_ksps;
   logic [9:0] high_level_pm, low_level_pm;
   logic [7:0] rst_tab [5] = '{8'h00, 8'h91, 8'he0, 8'h40, 8'h00};
   logic [9:0] hi_tab [8] = '{10'h3b6, 10'h39d, 10'h384, 10'h36b, 10'h352, 10'h320,
      10'h2ee, 10'h2bc};
   logic [9:0] lo_tab [8] = '{10'h032, 10'h04b, 10'h064, 10'h07d, 10'h096, 10'h0c8,
      10'h0fa, 10'h12c};
   localparam int TDIV = 4;
   int failures = 0;
   int num_checks = 0;
   initial forever #12.5 clock = ~clock;
   adcg_host_model u_adcg_host_model (.clock(clock), .frame_active(frame_active),
      .byte_valid(byte_valid), .byte_data(byte_data));
   adcg_config_regs #(.TEST_DIV_LOG2(TDIV)) u_adcg_config_regs (.clock(clock), .srst(srst),
      .frame_active(frame_active), .byte_valid(byte_valid), .byte_data(byte_data),
      .rd_addr(rd_addr), .rd_data(rd_data), .clock_source_pin(clock_source_pin),
      .multi_readback_mode(multi_readback_mode), .osc_out_en(osc_out_en),
      .output_rate_code(output_rate_code), .rate_ksps(rate_ksps),
      .resolution_24(resolution_24), .rate_invalid(rate_invalid), .mod_clk_en(mod_clk_en),
      .test_internal(test_internal), .test_amp_double(test_amp_double),
      .test_wave(test_wave), .ref_buffer_on(ref_buffer_on),
      .high_reference_sel(high_reference_sel), .amp_input_route(amp_input_route),
      .amp_power_on(amp_power_on), .high_level_pm(high_level_pm),
      .low_level_pm(low_level_pm));
   task automatic end_sim();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(negedge clock);
      rd_addr = a;
      @(negedge clock);
      chk({2'h0, rd_data}, {2'h0, exp}, "register read");
   endtask
   task automatic wr1(input logic [4:0] a, input logic [7:0] d);
      u_adcg_host_model.register_write_cmd(a, '{d});
   endtask
   // measures one half period of the test waveform between two level changes, bounded
   task automatic half_period(input int exp);
      int first;
      first = -1;
      last_wave = test_wave;
      for (int i = 0; i < 40; i++) begin
         @(negedge clock);
         if (test_wave !== last_wave) begin
            last_wave = test_wave;
            if (first >= 0) begin
               chk(10'(i - first), 10'(exp), "test half period");
               return;
            end
            first = i;
         end
      end
      chk(1'b0, 1'b1, "test waveform stuck");
      end_sim();
   endtask
   initial begin
      repeat (4) @(negedge clock);
      srst = 1'b0;
      for (int a = 1; a <= 4; a++) rd(5'(a), rst_tab[a]);
      chk({multi_readback_mode, osc_out_en, test_internal, ref_buffer_on}, 10'h0,
         "reset controls");
      chk(low_level_pm, 10'h032, "reset low level");
      $display("test reset values done");
      // fixed bits written with their fixed values, fault low bits zero
      u_adcg_host_model.register_write_cmd(5'h01, '{8'hd1, 8'hf4, 8'hec, 8'h60});
      rd(5'h01, 8'hd1);
      rd(5'h02, 8'hf4);
      rd(5'h03, 8'hec);
      rd(5'h04, 8'h60);
      chk({multi_readback_mode, test_internal, test_amp_double}, 10'h7,
         "mode and test");
      chk({ref_buffer_on, high_reference_sel, amp_input_route, amp_power_on}, 10'hf,
         "reference and amp");
      chk(high_level_pm, 10'h36b, "high level");
      $display("test multi register write done");
      for (int c = 0; c < 8; c++) begin
         wr1(5'h01, 8'h90 | 8'(c));
         @(negedge clock);
         chk(10'(output_rate_code), 10'(c), "rate code");
         chk(10'(rate_ksps), (c < 7) ? 10'h40 >> c : 10'h0, "rate");
         chk({resolution_24, rate_invalid}, {c >= 2 && c <= 6, c == 7}, "word");
         wr1(5'h04, {3'(c), 5'h00});
         @(negedge clock);
         chk(high_level_pm, hi_tab[c], "high level");
         chk(low_level_pm, lo_tab[c], "low level");
      end
      $display("test rate and threshold codes done");
      wr1(5'h02, 8'he2);
      @(negedge clock);
      chk(test_wave, 1'b0, "unused frequency");
      wr1(5'h02, 8'he3);
      @(negedge clock);
      chk(test_wave, 1'b1, "constant level");
      wr1(5'h02, 8'he0);
      half_period(1 << (TDIV - 1));
      wr1(5'h02, 8'he1);
      half_period(1 << (TDIV - 2));
      $display("test waveform done");
      // read opcode is not a write; unmapped address keeps nothing
      u_adcg_host_model.send('{8'h21, 8'h00, 8'h55});
      rd(5'h01, 8'h97);
      wr1(5'h05, 8'h5a);
      rd(5'h05, 8'h00);
      $display("test refused writes done");
      wr1(5'h01, 8'hb1);
      clock_source_pin = 1'b1;
      repeat (5) @(negedge clock);
      chk(osc_out_en, 1'b1, "oscillator out");
      clock_source_pin = 1'b0;
      repeat (5) @(negedge clock);
      chk(osc_out_en, 1'b0, "oscillator out off");
      last_wave = mod_clk_en;
      @(negedge clock);
      chk(mod_clk_en, !last_wave, "modulator divide");
      srst = 1'b1;
      @(negedge clock);
      srst = 1'b0;
      rd(5'h01, 8'h91);
      clock_source_pin = 1'b1;
      repeat (5) @(negedge clock);
      chk(osc_out_en, 1'b0, "oscillator out without enable bit");
      $display("test pin, divider and reset done");
      end_sim();
   end
endmodule
